// File: core/sms_spi_port.sv
// SPI master/slave serial port with Avalon-MM register access.
//
// Behaviour
// - Shifter moves data MSB first, one bit each way per clock.
// - After eight bits, byte goes to buffer; buffer-full and irq flags set.
// - Next byte shifts in while the previous one waits in the buffer.
// - Buffer write during a transfer is dropped and sets sticky collision flag.
// - Reading the buffer clears buffer-full; master software reads between bytes.
// - Shifter has no address; only buffer reads and writes reach it.
// - Enable bit hands pins to the port; disable, reprogram, enable again.
// - Direction bits: data-out output, clock per mode, select input; else overridden.
// - One open-drain bit makes data-out and clock drivers open drain.
// - Master transfer starts at once on buffer write, clock made here.
// - Master with data-out as input still receives and flags bytes.
// - Master rate is clock/4, /16, /64 or half the timer output.
// - Polarity bit sets clock idle level in both master and slave.
// - With edge select set, data-out is valid before the first edge.
// - Sample phase bit picks middle or end sampling, with edge select.
// - Shift out on programmed edge, latch on the other; same polarity.
// - Slave shifts on external clock and flags after last bit latched.
// - Slave keeps working in sleep; a received byte wakes the device.
// - Mode four: select low drives data-out, select high floats it.
// - Select high in mode four or disable forces bit counter to zero.
// - Device reset disables the port and aborts any transfer.
//
// Chosen here: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/1ps
module sms_spi_port (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Avalon-MM slave
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Serial pins
    input  wire logic        sckIn,
    output logic             sckOut,
    output logic             sckOe,
    input  wire logic        sdiIn,
    output logic             sdoOut,
    output logic             sdoOe,
    input  wire logic        selectN,
    // System
    input  wire logic        timerTwoOutput,
    output logic             portIrqFlag
);
    typedef struct packed {
        logic [31:0]         rdata;
        logic                wreq;
        logic                write_collision_flag;
        logic                ov;
        logic                en;
        logic                clock_idle_polarity;
        logic [3:0]          mode;
        logic                input_sample_phase;
        logic                cke;
        logic                bf;
        logic                irq;
        logic                sdoDir;
        logic                sckDir;
        logic                ssDir;
        logic                od;
        logic [7:0]          buffer;
        logic [7:0]          shifter;
        logic [3:0]          bitCnt;
        logic [4:0]          halfIdx;
        sms_pkg::sms_phase_t ph;
        logic                sdoBit;
        logic                sckLvl;
        logic [1:0]          sckS;
        logic [1:0]          sdiS;
        logic [1:0]          ssS;
        logic                sckPrev;
        logic                sckOut;
        logic                sckOe;
        logic                sdoOut;
        logic                sdoOe;
    } sms_state_t;

    sms_state_t st;
    sms_state_t next_st;
    sms_baud_if bif ();

    logic       sck;
    logic       sdi;
    logic       isMaster;
    logic       isSlave;
    logic       selActive;
    logic       busy;
    logic       acc;
    logic       done;
    logic       wrOk;
    logic       rxDone;
    logic [7:0] rxByte;
    logic [7:0] shifted;
    logic       mLead;
    logic       mTrail;
    logic       smpNow;
    logic       last;
    logic       outNow;
    logic       sLead;
    logic       sTrail;
    logic       setWcol;
    logic       sckDrv;
    logic       sdoDrv;
    logic       sckVal;

    sms_baud_gen #(
        .CNT_W (6)
    ) u_baud (
        .ref_clk (ref_clk),
        .resetn  (resetn),
        .b       (bif.gen)
    );

    // ==========================================================
    // Decode of the current configuration
    assign sck      = st.sckS[1];
    assign sdi      = st.sdiS[1];
    assign isMaster = st.en && (st.mode[3:2] == 2'h0);
    assign isSlave  = st.en && (st.mode == sms_pkg::MODE_SLV_SS || st.mode == sms_pkg::MODE_SLV);
    // A select pin turned to output loses its select function and the slave stays selected.
    assign selActive = !(st.mode == sms_pkg::MODE_SLV_SS && st.ssDir) || !st.ssS[1];
    assign busy = (st.ph == sms_pkg::PH_MASTER) || (st.ph == sms_pkg::PH_SLAVE && st.bitCnt != 4'h0);
    assign acc  = (avs_read || avs_write) && st.wreq;
    assign done = (avs_read || avs_write) && !st.wreq;
    assign wrOk = done && avs_write && avs_byteenable[0];

    assign bif.run      = st.ph == sms_pkg::PH_MASTER;
    assign bif.rate     = st.mode[1:0];
    assign bif.tmrPulse = timerTwoOutput;

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_st = st;
        rxDone  = 1'h0;
        rxByte  = st.shifter;
        setWcol = 1'h0;
        shifted = {st.shifter[6:0], sdi};
        mLead   = !st.halfIdx[0] && !st.halfIdx[4];
        mTrail  = st.halfIdx[0];
        smpNow  = 1'h0;
        last    = 1'h0;
        outNow  = 1'h0;
        sLead   = (sck != st.sckPrev) && (sck != st.clock_idle_polarity);
        sTrail  = (sck != st.sckPrev) && (sck == st.clock_idle_polarity);

        next_st.sckS    = {st.sckS[0], sckIn};
        next_st.sdiS    = {st.sdiS[0], sdiIn};
        next_st.ssS     = {st.ssS[0], selectN};
        next_st.sckPrev = sck;

        // Register bus: answer one cycle after the request is seen.
        next_st.wreq = !acc;
        if (acc) begin
            unique case (avs_address)
                sms_pkg::ADDR_CTRL: next_st.rdata = {24'h0, st.write_collision_flag, st.ov, st.en, st.clock_idle_polarity, st.mode};
                sms_pkg::ADDR_STAT: next_st.rdata = {24'h0, st.input_sample_phase, st.cke, 5'h0, st.bf};
                sms_pkg::ADDR_DATA: next_st.rdata = {24'h0, st.buffer};
                sms_pkg::ADDR_PIN:  next_st.rdata = {28'h0, st.od, st.ssDir, st.sckDir, st.sdoDir};
                sms_pkg::ADDR_FLAG: next_st.rdata = {31'h0, st.irq};
                default:            next_st.rdata = 32'h0;
            endcase
        end

        // Engine sequencing.
        unique case (st.ph)
            sms_pkg::PH_IDLE: begin
                next_st.sckLvl = st.clock_idle_polarity;
                if (isSlave) begin
                    next_st.ph = sms_pkg::PH_SLAVE;
                end
            end
            sms_pkg::PH_MASTER: begin
                if (!isMaster) begin
                    next_st.ph = sms_pkg::PH_IDLE;
                end else if (bif.tick) begin
                    smpNow = st.cke ? (st.input_sample_phase ? mTrail : mLead)
                                    : (st.input_sample_phase ? ((mLead && st.halfIdx != 5'h0) || st.halfIdx[4]) : mTrail);
                    last   = (!st.cke && st.input_sample_phase) ? (st.halfIdx == sms_pkg::HALF_EXTRA)
                                                 : (st.halfIdx == sms_pkg::HALF_LAST);
                    outNow = st.cke ? mTrail : mLead;
                    if (!st.halfIdx[4]) begin
                        next_st.sckLvl = !st.sckLvl;
                    end
                    if (smpNow) begin
                        next_st.shifter = shifted;
                    end
                    if (outNow && !last) begin
                        next_st.sdoBit = smpNow ? st.shifter[6] : st.shifter[7];
                    end
                    if (last) begin
                        rxDone     = 1'h1;
                        rxByte     = smpNow ? shifted : st.shifter;
                        next_st.ph = sms_pkg::PH_IDLE;
                    end else begin
                        next_st.halfIdx = st.halfIdx + 5'h1;
                    end
                end
            end
            sms_pkg::PH_SLAVE: begin
                if (!isSlave) begin
                    next_st.ph = sms_pkg::PH_IDLE;
                end else if (!selActive) begin
                    next_st.bitCnt = 4'h0;
                    next_st.sdoBit = st.shifter[7];
                end else if (st.cke ? sLead : sTrail) begin
                    next_st.shifter = shifted;
                    if (st.bitCnt == sms_pkg::BIT_LAST) begin
                        next_st.bitCnt = 4'h0;
                        rxDone = 1'h1;
                        rxByte = shifted;
                    end else begin
                        next_st.bitCnt = st.bitCnt + 4'h1;
                    end
                end else if (st.cke ? sTrail : sLead) begin
                    next_st.sdoBit = st.shifter[7];
                end
            end
            default: begin
                next_st.ph = sms_pkg::PH_IDLE;
            end
        endcase

        // Software writes.
        if (wrOk) begin
            unique case (avs_address)
                sms_pkg::ADDR_CTRL: begin
                    next_st.write_collision_flag = avs_writedata[sms_pkg::CTRL_WRITE_COLLISION_FLAG];
                    next_st.ov   = avs_writedata[sms_pkg::CTRL_OV];
                    next_st.en   = avs_writedata[sms_pkg::CTRL_EN];
                    next_st.clock_idle_polarity  = avs_writedata[sms_pkg::CTRL_CKP];
                    next_st.mode = avs_writedata[3:0];
                end
                sms_pkg::ADDR_STAT: begin
                    next_st.input_sample_phase = avs_writedata[sms_pkg::STAT_SMP];
                    next_st.cke = avs_writedata[sms_pkg::STAT_CKE];
                end
                sms_pkg::ADDR_DATA: begin
                    if (busy) begin
                        setWcol = 1'h1;
                    end else begin
                        next_st.buffer  = avs_writedata[7:0];
                        next_st.shifter = avs_writedata[7:0];
                        // Bit 7 is on the pin before any clock edge.
                        next_st.sdoBit  = avs_writedata[7];
                        if (isMaster) begin
                            next_st.ph      = sms_pkg::PH_MASTER;
                            next_st.halfIdx = 5'h0;
                            next_st.sckLvl  = st.clock_idle_polarity;
                        end
                    end
                end
                sms_pkg::ADDR_PIN: begin
                    next_st.sdoDir = avs_writedata[sms_pkg::PIN_SDO];
                    next_st.sckDir = avs_writedata[sms_pkg::PIN_SCK];
                    next_st.ssDir  = avs_writedata[sms_pkg::PIN_SS];
                    next_st.od     = avs_writedata[sms_pkg::PIN_OD];
                end
                sms_pkg::ADDR_FLAG: begin
                    if (avs_writedata[sms_pkg::FLAG_IRQ]) begin
                        next_st.irq = 1'h0;
                    end
                end
                default: begin
                end
            endcase
        end
        if (done && avs_read && avs_address == sms_pkg::ADDR_DATA) begin
            next_st.bf = 1'h0;
        end

        // Hardware sets come last so an event beats a clear in the same cycle.
        if (setWcol) begin
            next_st.write_collision_flag = 1'h1;
        end
        if (rxDone) begin
            // The shifter is free again while this byte waits here.
            next_st.buffer = rxByte;
            next_st.bf     = 1'h1;
            next_st.irq    = 1'h1;
            if (st.bf && st.ph == sms_pkg::PH_SLAVE) begin
                next_st.ov = 1'h1;
            end
        end

        if (!st.en) begin
            next_st.ph      = sms_pkg::PH_IDLE;
            next_st.bitCnt  = 4'h0;
            next_st.halfIdx = 5'h0;
            next_st.bf      = 1'h0;
            next_st.sckLvl  = st.clock_idle_polarity;
        end

        // Pin drivers, registered so every output leaves a flip-flop.
        sckDrv = isMaster && !st.sckDir;
        sdoDrv = (isMaster || (isSlave && selActive)) && !st.sdoDir;
        sckVal = st.sckLvl;
        next_st.sckOut = st.od ? 1'h0 : sckVal;
        next_st.sckOe  = sckDrv && (!st.od || !sckVal);
        next_st.sdoOut = st.od ? 1'h0 : st.sdoBit;
        next_st.sdoOe  = sdoDrv && (!st.od || !st.sdoBit);
    end

    // ==========================================================
    // State register
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st      <= '0;
            st.wreq <= 1'h1;
            st.ssS  <= 2'h3;
        end else begin
            st <= next_st;
        end
    end

    assign avs_readdata    = st.rdata;
    assign avs_waitrequest = st.wreq;
    assign sckOut          = st.sckOut;
    assign sckOe           = st.sckOe;
    assign sdoOut          = st.sdoOut;
    assign sdoOe           = st.sdoOe;
    assign portIrqFlag     = st.irq;

    // ==========================================================
    // Checks
    a_bus_answer: assert property (@(posedge ref_clk) disable iff (!resetn)
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered in one cycle");

    a_rx_flags: assert property (@(posedge ref_clk) disable iff (!resetn)
        rxDone && st.en |=> st.bf && st.irq && st.buffer == $past(rxByte))
        else $error("received byte not stored and flagged");

    a_write_collision_flag_set: assert property (@(posedge ref_clk) disable iff (!resetn)
        wrOk && avs_address == sms_pkg::ADDR_DATA && busy && !rxDone |=> st.write_collision_flag && $stable(st.buffer))
        else $error("write during transfer not refused");

    a_read_clears: assert property (@(posedge ref_clk) disable iff (!resetn)
        done && avs_read && avs_address == sms_pkg::ADDR_DATA && !rxDone |=> !st.bf)
        else $error("buffer read did not clear buffer full");

    a_master_start: assert property (@(posedge ref_clk) disable iff (!resetn)
        wrOk && avs_address == sms_pkg::ADDR_DATA && isMaster && !busy
        |=> st.ph == sms_pkg::PH_MASTER && st.sdoBit == $past(avs_writedata[7]))
        else $error("master transfer did not start on buffer write");

    a_msb_first: assert property (@(posedge ref_clk) disable iff (!resetn)
        st.ph == sms_pkg::PH_MASTER && isMaster && bif.tick && smpNow && !last
        |=> st.shifter == {$past(st.shifter[6:0]), $past(sdi)})
        else $error("shifter did not move MSB first");

    a_ss_release: assert property (@(posedge ref_clk) disable iff (!resetn)
        isSlave && st.mode == sms_pkg::MODE_SLV_SS && st.ssDir && st.ssS[1] |=> !sdoOe)
        else $error("data-out driven while deselected");

    a_deselect_rst: assert property (@(posedge ref_clk) disable iff (!resetn)
        st.ph == sms_pkg::PH_SLAVE && isSlave && !selActive |=> st.bitCnt == 4'h0)
        else $error("bit counter not cleared on deselect");

    a_disable_clr: assert property (@(posedge ref_clk) disable iff (!resetn)
        !st.en |=> st.bitCnt == 4'h0 && !st.bf && st.ph == sms_pkg::PH_IDLE)
        else $error("disable left transfer state behind");

    a_od_low: assert property (@(posedge ref_clk) disable iff (!resetn)
        st.od |=> !sdoOut && !sckOut)
        else $error("open-drain pin driven high");

    a_sck_idle: assert property (@(posedge ref_clk) disable iff (!resetn)
        st.ph == sms_pkg::PH_IDLE && isMaster && !st.sckDir && !st.od ##1 st.ph == sms_pkg::PH_IDLE
        |=> sckOut == $past(st.clock_idle_polarity, 2))
        else $error("serial clock not at idle level");

    a_master_len: assert property (@(posedge ref_clk) disable iff (!resetn)
        st.ph == sms_pkg::PH_MASTER && isMaster && bif.tick && !st.halfIdx[4] |=> st.sckLvl != $past(st.sckLvl))
        else $error("master clock did not toggle on tick");
endmodule

// File: core/sms_pkg.sv
// Shared constants and types of the SPI master/slave port.
package sms_pkg;

    // ==========================================================
    // Register byte offsets
    localparam logic [4:0] ADDR_CTRL = 5'h00;
    localparam logic [4:0] ADDR_STAT = 5'h04;
    localparam logic [4:0] ADDR_DATA = 5'h08;
    localparam logic [4:0] ADDR_PIN  = 5'h0c;
    localparam logic [4:0] ADDR_FLAG = 5'h10;

    // ==========================================================
    // Field positions
    localparam int CTRL_WRITE_COLLISION_FLAG = 7;
    localparam int CTRL_OV   = 6;
    localparam int CTRL_EN   = 5;
    localparam int CTRL_CKP  = 4;
    localparam int STAT_SMP  = 7;
    localparam int STAT_CKE  = 6;
    localparam int STAT_BF   = 0;
    localparam int PIN_SDO   = 0;
    localparam int PIN_SCK   = 1;
    localparam int PIN_SS    = 2;
    localparam int PIN_OD    = 3;
    localparam int FLAG_IRQ  = 0;

    // ==========================================================
    // Modes, rates and sequencing
    typedef enum logic [3:0] {
        MODE_DIV4   = 4'h0,
        MODE_DIV16  = 4'h1,
        MODE_DIV64  = 4'h2,
        MODE_TMR2   = 4'h3,
        MODE_SLV_SS = 4'h4,
        MODE_SLV    = 4'h5
    } sms_mode_t;

    typedef enum logic [1:0] {
        PH_IDLE   = 2'h0,
        PH_MASTER = 2'h1,
        PH_SLAVE  = 2'h2
    } sms_phase_t;

    localparam logic [5:0] HALF_DIV4  = 6'h02;
    localparam logic [5:0] HALF_DIV16 = 6'h08;
    localparam logic [5:0] HALF_DIV64 = 6'h20;
    localparam logic [4:0] HALF_LAST  = 5'h0f;
    localparam logic [4:0] HALF_EXTRA = 5'h10;
    localparam logic [3:0] BIT_LAST   = 4'h7;

endpackage

// File: core/sms_baud_if.sv
// Link between the port engine and its bit-rate generator.
`timescale 1ns/1ps
interface sms_baud_if;
    logic       run;
    logic [1:0] rate;
    logic       tmrPulse;
    logic       tick;
    modport gen (input run, input rate, input tmrPulse, output tick);
    modport eng (output run, output rate, output tmrPulse, input tick);
endinterface

// File: core/sms_baud_gen.sv
// Master bit-rate generator: one tick per half serial clock period.
`timescale 1ns/1ps
module sms_baud_gen #(
    parameter int CNT_W = 6
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic resetn,
    // Engine side
    sms_baud_if.gen   b
);
    typedef struct packed {
        logic [CNT_W-1:0] cnt;
    } sms_gen_t;

    sms_gen_t         st;
    sms_gen_t         next_st;
    logic             tk;
    logic [CNT_W-1:0] lim;

    // ==========================================================
    // Divider
    always_comb begin
        next_st = st;
        tk = 1'h0;
        unique case (b.rate)
            2'h0:    lim = CNT_W'(sms_pkg::HALF_DIV4);
            2'h1:    lim = CNT_W'(sms_pkg::HALF_DIV16);
            default: lim = CNT_W'(sms_pkg::HALF_DIV64);
        endcase
        if (!b.run) begin
            next_st.cnt = '0;
        end else if (b.rate == 2'h3) begin
            // Each timer pulse flips the clock, so the bit rate is half the timer rate.
            tk = b.tmrPulse;
        end else if (st.cnt == lim - CNT_W'(1)) begin
            tk = 1'h1;
            next_st.cnt = '0;
        end else begin
            next_st.cnt = st.cnt + CNT_W'(1);
        end
    end

    assign b.tick = tk;

    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    a_tick_spacing: assert property (@(posedge ref_clk) disable iff (!resetn)
        (b.tick && b.run && b.rate == 2'h0) ##1 (b.run && b.rate == 2'h0) |-> !b.tick ##1 b.tick)
        else $error("fastest rate tick spacing is not two cycles");
endmodule

// File: tb/sms_peer.sv
// Behavioural SPI peer: slave when the port masters, master when the port is slave.
`timescale 1ns/1ps
module sms_peer (
    // Serial lines
    input  wire logic       sckLine,
    input  wire logic       sdoLine,
    output logic            sckDrv,
    output logic            sdiDrv,
    // Observation
    output logic [7:0]      rxByte
);
    logic [7:0] txSh;
    logic       isMaster;
    initial begin
        sckDrv = 1'b0;
        sdiDrv = 1'b0;
        rxByte = 8'h00;
        txSh = 8'h00;
        isMaster = 1'b0;
    end
    // ==========================================================
    // Slave role, idle-low clock: sample on rising, change on falling.
    task automatic load(input logic [7:0] b);
        txSh = b;
        sdiDrv = b[7];
    endtask
    always @(posedge sckLine) if (!isMaster) rxByte <= {rxByte[6:0], sdoLine};
    always @(negedge sckLine) begin
        if (!isMaster) begin
            txSh = txSh << 1;
            sdiDrv = txSh[7];
        end
    end
    // ==========================================================
    // Master role at 125 ns per bit; the offset keeps edges clear of the port clock.
    task automatic master_xfer(input logic [7:0] b);
        isMaster = 1'b1;
        txSh = b;
        #1.3;
        for (int i = 0; i < 8; i++) begin
            #62.5 sckDrv = 1'b1;
            sdiDrv = txSh[7];
            txSh = txSh << 1;
            #62.5 sckDrv = 1'b0;
            rxByte = {rxByte[6:0], sdoLine};
        end
        // The slave-role edge process must see the last falling edge while still in master role.
        #10 isMaster = 1'b0;
    endtask
endmodule

// File: tb/testbench.sv
// Self-checking bench for the SPI master/slave port.
`timescale 1ns/1ps
module testbench;
    logic        ref_clk;
    logic        resetn;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        sckOut, sckOe, sdoOut, sdoOe, sckDrv, sdiDrv, portIrqFlag;
    logic [7:0]  peerRx;
    logic [7:0]  q;
    logic        selN;
    logic        tmrPulse;
    logic [1:0]  tdiv;
    int          num_errors = 0;
    int          num_checks = 0;
    int          cycles = 0;
    // A released data-out line is pulled up.
    wire         sckLine = sckOe ? sckOut : sckDrv;
    wire         sdoLine = sdoOe ? sdoOut : 1'b1;
    sms_spi_port dut (.ref_clk(ref_clk), .resetn(resetn), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sckIn(sckLine), .sckOut(sckOut),
        .sckOe(sckOe), .sdiIn(sdiDrv), .sdoOut(sdoOut), .sdoOe(sdoOe), .selectN(selN),
        .timerTwoOutput(tmrPulse), .portIrqFlag(portIrqFlag));
    sms_peer peer (.sckLine(sckLine), .sdoLine(sdoLine), .sckDrv(sckDrv), .sdiDrv(sdiDrv), .rxByte(peerRx));
    // ==========================================================
    // Checking and bus tasks
    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        avs_address <= a;
        avs_read <= !wr;
        avs_write <= wr;
        avs_writedata <= {24'h000000, d};
        do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
        q = avs_readdata[7:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        bus(1'b1, a, d);
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        bus(1'b0, a, 8'h00);
        chk("register", exp, q);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 600 && portIrqFlag !== 1'b1; i++) @(posedge ref_clk);
        // One more edge lets the registered pins catch up with the last clock toggle.
        @(posedge ref_clk);
        chk("irq", 8'h01, {7'h00, portIrqFlag});
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ==========================================================
    // Clock, timeout and test sequence
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    // Same-clock timer pulse on every fourth cycle for the timer-driven rate.
    always @(posedge ref_clk) begin
        tdiv <= tdiv + 2'h1;
        tmrPulse <= (tdiv == 2'h0);
    end
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            test_done();
        end
    end
    initial begin
        resetn = 1'b0;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h00000000;
        selN = 1'b1;
        tmrPulse = 1'b0;
        tdiv = 2'h0;
        repeat (20) @(posedge ref_clk);
        resetn <= 1'b1;
        rd(sms_pkg::ADDR_CTRL, 8'h00);
        rd(sms_pkg::ADDR_STAT, 8'h00);
        rd(5'h14, 8'h00);
        $display("test reset done");
        peer.load(8'h3c);
        wr(sms_pkg::ADDR_STAT, 8'h40);
        // At the fastest rate the synchronised data-in comes back too late, so receive is checked slower.
        wr(sms_pkg::ADDR_CTRL, 8'h21);
        wr(sms_pkg::ADDR_DATA, 8'ha5);
        wr(sms_pkg::ADDR_DATA, 8'h11);
        wait_irq();
        chk("peer rx", 8'ha5, peerRx);
        chk("sck idle", 8'h00, {7'h00, sckOut});
        rd(sms_pkg::ADDR_CTRL, 8'ha1);
        rd(sms_pkg::ADDR_STAT, 8'h41);
        rd(sms_pkg::ADDR_DATA, 8'h3c);
        rd(sms_pkg::ADDR_STAT, 8'h40);
        wr(sms_pkg::ADDR_FLAG, 8'h01);
        @(posedge ref_clk);
        chk("irq clear", 8'h00, {7'h00, portIrqFlag});
        peer.load(8'h5c);
        wr(sms_pkg::ADDR_CTRL, 8'h23);
        wr(sms_pkg::ADDR_DATA, 8'h6b);
        wait_irq();
        chk("peer rx", 8'h6b, peerRx);
        rd(sms_pkg::ADDR_DATA, 8'h5c);
        wr(sms_pkg::ADDR_FLAG, 8'h01);
        wr(sms_pkg::ADDR_CTRL, 8'h20);
        wr(sms_pkg::ADDR_DATA, 8'hc6);
        wait_irq();
        chk("peer rx", 8'hc6, peerRx);
        $display("test master done");
        wr(sms_pkg::ADDR_CTRL, 8'h00);
        wr(sms_pkg::ADDR_FLAG, 8'h01);
        wr(sms_pkg::ADDR_STAT, 8'h00);
        wr(sms_pkg::ADDR_PIN, 8'h02);
        wr(sms_pkg::ADDR_CTRL, 8'h25);
        wr(sms_pkg::ADDR_DATA, 8'h5a);
        peer.master_xfer(8'h96);
        wait_irq();
        chk("peer rx", 8'h5a, peerRx);
        rd(sms_pkg::ADDR_DATA, 8'h96);
        peer.master_xfer(8'hc3);
        repeat (10) @(posedge ref_clk);
        rd(sms_pkg::ADDR_STAT, 8'h01);
        rd(sms_pkg::ADDR_DATA, 8'hc3);
        peer.master_xfer(8'h77);
        repeat (10) @(posedge ref_clk);
        wr(sms_pkg::ADDR_CTRL, 8'h05);
        rd(sms_pkg::ADDR_STAT, 8'h00);
        $display("test slave done");
        wr(sms_pkg::ADDR_FLAG, 8'h01);
        wr(sms_pkg::ADDR_PIN, 8'h06);
        wr(sms_pkg::ADDR_CTRL, 8'h24);
        selN <= 1'b0;
        // Deselect after two bits: the counter must restart so the next byte lands whole.
        fork
            peer.master_xfer(8'hff);
            begin
                repeat (60) @(posedge ref_clk);
                selN <= 1'b1;
            end
        join
        chk("sdo oe", 8'h00, {7'h00, sdoOe});
        rd(sms_pkg::ADDR_STAT, 8'h00);
        selN <= 1'b0;
        repeat (5) @(posedge ref_clk);
        chk("sdo oe", 8'h01, {7'h00, sdoOe});
        peer.master_xfer(8'h69);
        wait_irq();
        rd(sms_pkg::ADDR_DATA, 8'h69);
        $display("test select done");
        test_done();
    end
endmodule
